/* verilog/upfm_top.sv */
// Port FIFO area manager: APB registers, area FIFOs, descriptor reply, command capture
`timescale 1ns/100ps
`include "upfm_regs.svh"
module upfm_top #(
  parameter int AW = 8
) (
  // Clock and reset
  input  logic        CLK_SYS,
  input  logic        SRST,
  // APB slave
  input  logic        PSEL,
  input  logic        PENABLE,
  input  logic        PWRITE,
  input  logic [11:0] PADDR,
  input  logic [31:0] PWDATA,
  input  logic [3:0]  PSTRB,
  output logic [31:0] PRDATA,
  output logic        PREADY,
  output logic        PSLVERR,
  // USB OUT side
  input  logic        USB_PORT,
  input  logic        USB_OUT_VLD,
  input  logic [2:0]  USB_OUT_EP,
  input  logic [7:0]  USB_OUT_DATA,
  input  logic        USB_OUT_END,
  input  logic        USB_OUT_TOK,
  // USB IN side
  input  logic        USB_IN_TOK,
  input  logic [2:0]  USB_IN_EP,
  output logic        TX_VALID,
  output logic [7:0]  TX_DATA,
  output logic        TX_END
);
  localparam int N = 2**AW;

  // Room for both fixed regions and an 8-bit packet length
  if (AW < 7 || AW > 15)
  begin : g_chk
    $error("AW out of range");
  end

  logic [7:0]    mem_q [2][N];
  logic [7:0]    mem_d [2][N];
  logic [AW-1:0] ast_q [2][6], ast_d [2][6];
  logic [AW-1:0] aen_q [2][6], aen_d [2][6];
  logic [5:0]    att_q [2][6], att_d [2][6];
  logic [AW:0]   occ_q [2][6], occ_d [2][6];
  logic [AW-1:0] awp_q [2][6], awp_d [2][6];
  logic [AW-1:0] arp_q [2][6], arp_d [2][6];
  logic [AW-1:0] wptr_q [2], wptr_d [2];
  logic [7:0]    rwin_q [32], rwin_d [32];
  logic          cport_q, cport_d, reply_q, reply_d, dir_q, dir_d;
  logic [4:0]    cbw_q, cbw_d, ridx_q, ridx_d;
  logic [2:0]    sts_q, sts_d, tarea_q, tarea_d;
  logic [AW-1:0] dadr_q, dadr_d, dptr_q, dptr_d;
  logic [15:0]   dsize_q, dsize_d, drem_q, drem_d;
  logic [7:0]    max_q, max_d, tlen_q, tlen_d, txd_q, txd_d;
  logic [5:0]    ccnt_q, ccnt_d;
  logic          rbusy_q, rbusy_d, tport_q, tport_d;
  logic          txv_q, txv_d, txe_q, txe_d;
  logic [31:0]   prd_q, prd_d;
  upfm_pkg::upfm_tx_t st_q, st_d;
  logic [11:0]   blk;
  logic [2:0]    aix;
  logic          hit, wr, ocb;

  // Area size and wrap step
  function automatic logic [AW:0] size_of(logic [AW-1:0] s, logic [AW-1:0] e);
    return (AW+1)'(e) - (AW+1)'(s) + 1'b1;
  endfunction : size_of

  function automatic logic [AW-1:0] step(logic [AW-1:0] p, logic [AW-1:0] s,
                                         logic [AW-1:0] e);
    return (p == e) ? s : p + 1'b1;
  endfunction : step

  // Address decode; slave never waits
  assign blk     = {PADDR[11:5], 5'h00};
  assign aix     = PADDR[4:2];
  assign wr      = PSEL && PENABLE && PWRITE && hit; // Unmapped or misaligned writes dropped
  assign hit     = PADDR[1:0] == 2'h0 && (PADDR <= `UPFM_RDCTL || blk == `UPFM_RWIN ||
                   ((blk == `UPFM_ACFG || blk == `UPFM_AJOIN || blk == `UPFM_AOCC)
                    && aix < 3'd6));
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;
  assign PRDATA  = prd_q;
  assign TX_VALID = txv_q;
  assign TX_DATA  = txd_q;
  assign TX_END   = txe_q;
  // Bulk OUT endpoint a..e in command-block mode
  assign ocb = USB_OUT_EP != 3'd0 && USB_OUT_EP <= 3'd5 && cbw_q[3'(USB_OUT_EP - 3'd1)];

  // Next state of registers, areas, memory and transmitter
  always_comb
  begin
    logic [AW-1:0] a;
    logic [AW:0]   oc;
    logic [2:0]    oa;
    logic [2:0]    ia;
    logic [AW-1:0] n;
    logic [5:0]    clr;
    mem_d   = mem_q;
    ast_d   = ast_q;
    aen_d   = aen_q;
    att_d   = att_q;
    occ_d   = occ_q;
    awp_d   = awp_q;
    arp_d   = arp_q;
    wptr_d  = wptr_q;
    rwin_d  = rwin_q;
    cport_d = cport_q;
    reply_d = reply_q;
    dir_d   = dir_q;
    cbw_d   = cbw_q;
    ridx_d  = ridx_q;
    sts_d   = sts_q;
    tarea_d = tarea_q;
    dadr_d  = dadr_q;
    dptr_d  = dptr_q;
    dsize_d = dsize_q;
    drem_d  = drem_q;
    max_d   = max_q;
    tlen_d  = tlen_q;
    txd_d   = txd_q;
    ccnt_d  = ccnt_q;
    rbusy_d = rbusy_q;
    tport_d = tport_q;
    txv_d   = 1'b0;
    txe_d   = 1'b0;
    prd_d   = prd_q;
    st_d    = st_q;
    a   = '0;
    oc  = '0;
    oa  = 3'd7;
    ia  = 3'd7;
    n   = '0;
    clr = 6'h00;
    // Register writes; hardware events below override them, except an area clear, which wins
    if (wr)
    begin
      if (PADDR == `UPFM_CTRL)
      begin
        cport_d = PWDATA[`UPFM_CTRL_PORT];
        reply_d = PWDATA[`UPFM_CTRL_RPLY];
        dir_d   = PWDATA[`UPFM_CTRL_DIR];
        cbw_d   = PWDATA[`UPFM_CTRL_CBW +: 5];
        // Arming latches address and size loaded beforehand
        if (PWDATA[`UPFM_CTRL_RPLY] && !reply_q)
        begin
          dptr_d = dadr_q;
          drem_d = dsize_q;
        end
      end
      else if (PADDR == `UPFM_STS)
        sts_d = sts_q & ~PWDATA[2:0];
      else if (PADDR == `UPFM_WPTR)
        wptr_d[cport_q] = PWDATA[AW-1:0];
      else if (PADDR == `UPFM_WWIN)
      begin
        // Enabled lanes go to consecutive bytes, ignoring area bounds
        for (int k = 0; k < 4; k++)
          if (PSTRB[k])
          begin
            mem_d[cport_q][wptr_q[cport_q] + n] = PWDATA[8*k +: 8]; // RQ10
            n = n + 1'b1;
          end
        wptr_d[cport_q] = wptr_q[cport_q] + n; // RQ10
      end
      else if (PADDR == `UPFM_DADR)
        dadr_d = PWDATA[AW-1:0];
      else if (PADDR == `UPFM_DSIZE)
        dsize_d = PWDATA[15:0];
      else if (PADDR == `UPFM_MAXP)
        max_d = PWDATA[7:0];
      else if (PADDR == `UPFM_ACLR)
        clr = PWDATA[5:0];
      else if (PADDR == `UPFM_RDCTL)
      begin
        if (PWDATA[0] && !rbusy_q)
        begin
          rbusy_d = 1'b1;
          ridx_d  = 5'h00;
        end
      end
      else if (blk == `UPFM_ACFG && aix < 3'd6)
      begin
        // General areas cannot start inside the fixed block regions
        a = PWDATA[AW-1:0];
        ast_d[cport_q][aix] = (a < AW'(`UPFM_GEN_BASE)) ? AW'(`UPFM_GEN_BASE) : a; // RQ1 RQ2 RQ3
        aen_d[cport_q][aix] = PWDATA[`UPFM_ACFG_END +: AW]; // RQ3
        occ_d[cport_q][aix] = '0;
        awp_d[cport_q][aix] = ast_d[cport_q][aix];
        arp_d[cport_q][aix] = ast_d[cport_q][aix];
      end
      else if (blk == `UPFM_AJOIN && aix < 3'd6)
        att_d[cport_q][aix] = PWDATA[5:0]; // RQ5
    end
    // OUT data: command blocks or the joined area of the packet's port
    for (int i = 0; i < 6; i++)
      if (USB_OUT_EP <= 3'd5 && att_q[USB_PORT][i][USB_OUT_EP])
        oa = 3'(i);
    if (USB_OUT_VLD && ocb)
    begin
      if (ccnt_q < 6'(`UPFM_CBW_SIZE))
        mem_d[USB_PORT][AW'(`UPFM_CBW_BASE) + AW'(ccnt_q)] = USB_OUT_DATA; // RQ18 RQ20 RQ4
      if (ccnt_q != 6'h3f)
        ccnt_d = ccnt_q + 1'b1;
    end
    else if (USB_OUT_VLD && oa != 3'd7 &&
             occ_q[USB_PORT][oa] != size_of(ast_q[USB_PORT][oa], aen_q[USB_PORT][oa]))
    begin
      mem_d[USB_PORT][awp_q[USB_PORT][oa]] = USB_OUT_DATA; // RQ4
      awp_d[USB_PORT][oa] = step(awp_q[USB_PORT][oa], ast_q[USB_PORT][oa],
                                 aen_q[USB_PORT][oa]); // RQ23
      occ_d[USB_PORT][oa] = occ_q[USB_PORT][oa] + 1'b1; // RQ7
    end
    // Only a 31-byte packet counts as a valid command block
    if (USB_OUT_END && ocb)
    begin
      if (ccnt_q != 6'(`UPFM_CBW_LEN))
        sts_d[`UPFM_STS_CERR] = 1'b1; // RQ19
      ccnt_d = 6'h00;
    end
    // OUT token on endpoint 0 ends the reply
    if (USB_OUT_TOK && reply_q)
    begin
      reply_d = 1'b0; // RQ16
      sts_d[`UPFM_STS_DCMP] = 1'b1; // RQ16
    end
    // IN packet transmitter
    case (st_q)
      upfm_pkg::TX_IDLE:
        if (USB_IN_TOK)
        begin
          tport_d = USB_PORT;
          if (USB_IN_EP == 3'd0 && reply_q && dir_q) // RQ9
          begin
            st_d   = upfm_pkg::TX_DESC;
            tlen_d = (drem_q < 16'(max_q)) ? drem_q[7:0] : max_q; // RQ14 RQ15
          end
          else
          begin
            for (int i = 0; i < 6; i++)
              if (USB_IN_EP <= 3'd5 && att_q[USB_PORT][i][USB_IN_EP])
                ia = 3'(i);
            if (ia != 3'd7)
            begin
              oc      = occ_q[USB_PORT][ia];
              tarea_d = ia;
              tlen_d  = (oc < (AW+1)'(max_q)) ? oc[7:0] : max_q;
              st_d    = upfm_pkg::TX_AREA;
            end
          end
        end
      default:
        if (tlen_q == 8'h00 ||
            (st_q == upfm_pkg::TX_AREA && occ_q[tport_q][tarea_q] == '0))
        begin
          txe_d = 1'b1;
          st_d  = upfm_pkg::TX_IDLE;
        end
        else
        begin
          txv_d  = 1'b1;
          tlen_d = tlen_q - 1'b1; // RQ14
          if (st_q == upfm_pkg::TX_DESC)
          begin
            txd_d  = mem_q[tport_q][dptr_q];
            dptr_d = dptr_q + 1'b1;
            drem_d = drem_q - 1'b1;
          end
          else
          begin
            txd_d = mem_q[tport_q][arp_q[tport_q][tarea_q]];
            arp_d[tport_q][tarea_q] = step(arp_q[tport_q][tarea_q], ast_q[tport_q][tarea_q],
                                           aen_q[tport_q][tarea_q]); // RQ23
            occ_d[tport_q][tarea_q] = occ_d[tport_q][tarea_q] - 1'b1; // RQ23
          end
        end
    endcase
    // Clear wins over a same-cycle push or pop; RAM is left alone
    for (int i = 0; i < 6; i++)
      if (clr[i])
      begin
        occ_d[cport_q][i] = '0; // RQ7 RQ8
        awp_d[cport_q][i] = ast_q[cport_q][i];
        arp_d[cport_q][i] = ast_q[cport_q][i];
      end
    // Block copy, one byte a cycle into read window 00..1e
    if (rbusy_q)
    begin
      rwin_d[ridx_q] = mem_q[cport_q][AW'(`UPFM_CBW_BASE) + AW'(ridx_q)]; // RQ21
      ridx_d = ridx_q + 1'b1;
      if (ridx_q == 5'(`UPFM_CBW_LEN - 8'h01))
      begin
        rbusy_d = 1'b0;
        sts_d[`UPFM_STS_RDC] = 1'b1; // RQ21
      end
    end
    // Read data captured in the setup phase
    if (PSEL && !PENABLE && !PWRITE)
    begin
      prd_d = 32'h0000_0000; // RQ11
      if (!hit)
        prd_d = 32'h0000_0000;
      else if (PADDR == `UPFM_CTRL)
        prd_d = {19'h0, cbw_q, 5'h00, dir_q, reply_q, cport_q};
      else if (PADDR == `UPFM_STS)
        prd_d = {29'h0, sts_q};
      else if (PADDR == `UPFM_WPTR)
        prd_d = 32'(wptr_q[cport_q]);
      else if (PADDR == `UPFM_DADR)
        prd_d = 32'(dadr_q);
      else if (PADDR == `UPFM_DSIZE)
        prd_d = {16'h0000, dsize_q};
      else if (PADDR == `UPFM_MAXP)
        prd_d = {24'h000000, max_q};
      else if (PADDR == `UPFM_RDCTL)
        prd_d = {31'h0, rbusy_q};
      else if (blk == `UPFM_ACFG && aix < 3'd6)
        prd_d = 32'(ast_q[cport_q][aix]) | (32'(aen_q[cport_q][aix]) << `UPFM_ACFG_END);
      else if (blk == `UPFM_AJOIN && aix < 3'd6)
        prd_d = 32'(att_q[cport_q][aix]);
      else if (blk == `UPFM_AOCC && aix < 3'd6)
      begin
        oc    = occ_q[cport_q][aix];
        prd_d = 32'(oc);
        prd_d[`UPFM_AOCC_EMP] = oc == '0; // RQ23
        prd_d[`UPFM_AOCC_FUL] = oc == size_of(ast_q[cport_q][aix], aen_q[cport_q][aix]);
      end
      else if (blk == `UPFM_RWIN)
        prd_d = {rwin_q[{aix, 2'd3}], rwin_q[{aix, 2'd2}],
                 rwin_q[{aix, 2'd1}], rwin_q[{aix, 2'd0}]};
    end
  end

  // Memory holds data only, so it needs no reset
  always_ff @(posedge CLK_SYS)
  begin
    mem_q <= mem_d;
  end

  // Control and status registers
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      ast_q   <= '{default: '{default: '0}};
      aen_q   <= '{default: '{default: '0}};
      att_q   <= '{default: '{default: '0}};
      occ_q   <= '{default: '{default: '0}};
      awp_q   <= '{default: '{default: '0}};
      arp_q   <= '{default: '{default: '0}};
      wptr_q  <= '{default: '0};
      rwin_q  <= '{default: '0};
      cport_q <= 1'b0;
      reply_q <= 1'b0;
      dir_q   <= 1'b0;
      cbw_q   <= 5'h00;
      ridx_q  <= 5'h00;
      sts_q   <= 3'h0;
      tarea_q <= 3'h0;
      dadr_q  <= '0;
      dptr_q  <= '0;
      dsize_q <= 16'h0000;
      drem_q  <= 16'h0000;
      max_q   <= `UPFM_MAXP_RST;
      tlen_q  <= 8'h00;
      txd_q   <= 8'h00;
      ccnt_q  <= 6'h00;
      rbusy_q <= 1'b0;
      tport_q <= 1'b0;
      txv_q   <= 1'b0;
      txe_q   <= 1'b0;
      prd_q   <= 32'h0000_0000;
      st_q    <= upfm_pkg::TX_IDLE;
    end
    else
    begin
      ast_q   <= ast_d;
      aen_q   <= aen_d;
      att_q   <= att_d;
      occ_q   <= occ_d;
      awp_q   <= awp_d;
      arp_q   <= arp_d;
      wptr_q  <= wptr_d;
      rwin_q  <= rwin_d;
      cport_q <= cport_d;
      reply_q <= reply_d;
      dir_q   <= dir_d;
      cbw_q   <= cbw_d;
      ridx_q  <= ridx_d;
      sts_q   <= sts_d;
      tarea_q <= tarea_d;
      dadr_q  <= dadr_d;
      dptr_q  <= dptr_d;
      dsize_q <= dsize_d;
      drem_q  <= drem_d;
      max_q   <= max_d;
      tlen_q  <= tlen_d;
      txd_q   <= txd_d;
      ccnt_q  <= ccnt_d;
      rbusy_q <= rbusy_d;
      tport_q <= tport_d;
      txv_q   <= txv_d;
      txe_q   <= txe_d;
      prd_q   <= prd_d;
      st_q    <= st_d;
    end
  end

  // Checks on the block's internal registers and read data
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  a_win_advance: assert property (wr && PADDR == `UPFM_WWIN && PSTRB == 4'hf // RQ10
    |=> wptr_q[cport_q] == $past(wptr_q[cport_q]) + AW'(4)) else $error("window pointer step");
  a_win_zero: assert property (PSEL && !PENABLE && !PWRITE && PADDR == `UPFM_WWIN // RQ11
    |=> PRDATA == 32'h0000_0000) else $error("window read not zero");
  a_clear_empty: assert property (wr && PADDR == `UPFM_ACLR && PWDATA[0] // RQ7
    |=> occ_q[cport_q][0] == '0) else $error("area 0 not emptied");
  a_desc_done: assert property (USB_OUT_TOK && reply_q // RQ16
    |=> !reply_q && sts_q[`UPFM_STS_DCMP]) else $error("reply not closed");
  a_cbw_error: assert property (USB_OUT_END && ocb && ccnt_q != 6'h1f // RQ19
    |=> sts_q[`UPFM_STS_CERR]) else $error("length error missed");
  a_read_done: assert property ($rose(rbusy_q) // RQ21
    |-> ##31 !rbusy_q && sts_q[`UPFM_STS_RDC]) else $error("block copy timing");
  a_desc_ep0: assert property ($rose(st_q == upfm_pkg::TX_DESC) // RQ9
    |-> $past(USB_IN_EP) == 3'd0 && $past(dir_q)) else $error("reply off endpoint 0");
  a_short_pkt: assert property (st_q == upfm_pkg::TX_IDLE && USB_IN_TOK && USB_IN_EP == 3'd0 &&
    reply_q && dir_q && drem_q < 16'(max_q) |=> tlen_q == $past(drem_q[7:0])) // RQ15
    else $error("short packet length");
  a_start_rsv: assert property (wr && blk == `UPFM_ACFG && aix < 3'd6 // RQ2
    |=> ast_q[cport_q][$past(aix)] >= AW'(`UPFM_GEN_BASE)) else $error("area in fixed region");
endmodule : upfm_top

/* verilog/upfm_regs.svh */
// Register map, field positions and fixed regions of the port FIFO area manager
// Behaviour
// RQ1 - 32-byte command block region at zero
// RQ2 - 16-byte status block region at 0x20
// RQ3 - Six areas with programmable start, end
// RQ4 - Each USB port owns separate memory
// RQ5 - Join bits attach areas to endpoints
// RQ6 - Software never joins one endpoint twice
// RQ7 - Area clear bit empties occupancy count
// RQ8 - Clearing occupancy leaves RAM contents intact
// RQ9 - Descriptor reply only on endpoint 0 IN
// RQ10 - Write window stores, pointer advances by bytes
// RQ11 - Write window reads back as zero
// RQ12 - Software loads address, size, then arms
// RQ13 - Software drops protection before forced NAK
// RQ14 - Reply packets cut to endpoint-0 max
// RQ15 - Remainder below max goes as short
// RQ16 - OUT during reply disarms, flags completion
// RQ17 - Software then handles the status stage
// RQ18 - 31-byte bulk OUT lands in command region
// RQ19 - Wrong-length command block flags error, dropped; its bytes still land in the command region
// RQ20 - Command blocks bypass the endpoint area
// RQ21 - Read trigger copies block, then flags done
// RQ22 - Descriptors may use any unused region
// RQ23 - Areas wrap within bounds, report empty/full
`ifndef UPFM_REGS_SVH
`define UPFM_REGS_SVH
`define UPFM_CTRL      12'h000
`define UPFM_STS       12'h004
`define UPFM_WPTR      12'h008
`define UPFM_WWIN      12'h00c
`define UPFM_DADR      12'h010
`define UPFM_DSIZE     12'h014
`define UPFM_MAXP      12'h018
`define UPFM_ACLR      12'h01c
`define UPFM_RDCTL     12'h020
`define UPFM_ACFG      12'h040
`define UPFM_AJOIN     12'h060
`define UPFM_AOCC      12'h080
`define UPFM_RWIN      12'h100
`define UPFM_CTRL_PORT 0
`define UPFM_CTRL_RPLY 1
`define UPFM_CTRL_DIR  2
`define UPFM_CTRL_CBW  8
`define UPFM_STS_DCMP  0
`define UPFM_STS_RDC   1
`define UPFM_STS_CERR  2
`define UPFM_ACFG_END  16
`define UPFM_AOCC_EMP  16
`define UPFM_AOCC_FUL  17
`define UPFM_CBW_BASE  8'h00
`define UPFM_CBW_SIZE  8'h20
`define UPFM_CBW_LEN   8'h1f
`define UPFM_CSW_BASE  8'h20
`define UPFM_GEN_BASE  8'h30
`define UPFM_MAXP_RST  8'h40
`endif

/* verilog/upfm_pkg.sv */
// Shared types of the port FIFO area manager
package upfm_pkg;
  // Packet transmitter states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_DESC = 2'b01,
    TX_AREA = 2'b10
  } upfm_tx_t;
endpackage : upfm_pkg

/* sim/upfm_usb_host.sv */
// Behavioural USB far side: sends OUT packets and IN tokens, collects the replies
`timescale 1ns/100ps
module upfm_usb_host (
  // Clock
  input  logic       clk,
  // Toward the block
  output logic       usb_port,
  output logic       out_vld,
  output logic [2:0] out_ep,
  output logic [7:0] out_data,
  output logic       out_end,
  output logic       out_tok,
  output logic       in_tok,
  output logic [2:0] in_ep,
  // From the block
  input  logic       tx_valid,
  input  logic [7:0] tx_data,
  input  logic       tx_end
);
  logic [7:0] rx_q [$];

  // Quiet bus at time zero
  initial
  begin
    usb_port = 1'b0;
    out_vld  = 1'b0;
    out_ep   = 3'h0;
    out_data = 8'h00;
    out_end  = 1'b0;
    out_tok  = 1'b0;
    in_tok   = 1'b0;
    in_ep    = 3'h0;
  end

  // Whole OUT packet, byte strobes then the end pulse one cycle later
  task automatic send_out(input logic [2:0] ep, input logic [7:0] b [$]);
    @(posedge clk);
    out_ep <= ep;
    foreach (b[i])
    begin
      out_vld  <= 1'b1;
      out_data <= b[i];
      @(posedge clk);
    end
    out_vld  <= 1'b0;
    out_data <= ~b[b.size()-1];  // Released bus shows the inverse, never a stale byte
    out_end  <= 1'b1;
    @(posedge clk);
    out_end <= 1'b0;
  endtask : send_out

  // OUT token on endpoint 0, starts the status stage
  task automatic pulse_out_tok();
    @(posedge clk);
    out_tok <= 1'b1;
    @(posedge clk);
    out_tok <= 1'b0;
  endtask : pulse_out_tok

  // IN token; next token only after the packet end or a silent spell
  task automatic in_token(input logic [2:0] ep, output bit ended);
    rx_q.delete();
    ended = 1'b0;
    @(posedge clk);
    in_tok <= 1'b1;
    in_ep  <= ep;
    @(posedge clk);
    in_tok <= 1'b0;
    repeat (40)
    begin
      @(posedge clk);
      if (tx_valid === 1'b1)
        rx_q.push_back(tx_data);
      if (tx_end === 1'b1)
      begin
        ended = 1'b1;
        break;
      end
    end
  endtask : in_token

  // Port select, changed just after an edge like every other strobe
  task automatic set_port(input logic p);
    @(posedge clk);
    usb_port <= p;
  endtask : set_port
endmodule : upfm_usb_host

/* sim/upfm_bench.sv */
// Self-checking bench for the port FIFO area manager
`timescale 1ns/100ps
`include "upfm_regs.svh"
module usb_port_fifo_area_manager_bench;
  logic        clk_sys, srst, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, d, wptr;
  logic [3:0]  pstrb, s;
  logic        usb_port, out_vld, out_end, out_tok, in_tok, tx_valid, tx_end;
  logic [2:0]  out_ep, in_ep;
  logic [7:0]  out_data, tx_data;
  logic [7:0]  mem [0:255];
  logic [7:0]  cbw [0:31];
  logic [7:0]  pkt [$];
  int          fail_count, n_checks;

  upfm_top upfm_top_i (.CLK_SYS(clk_sys), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .USB_PORT(usb_port), .USB_OUT_VLD(out_vld),
    .USB_OUT_EP(out_ep), .USB_OUT_DATA(out_data), .USB_OUT_END(out_end),
    .USB_OUT_TOK(out_tok), .USB_IN_TOK(in_tok), .USB_IN_EP(in_ep), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_END(tx_end));
  upfm_usb_host upfm_usb_host_i (.clk(clk_sys), .usb_port(usb_port), .out_vld(out_vld),
    .out_ep(out_ep), .out_data(out_data), .out_end(out_end), .out_tok(out_tok),
    .in_tok(in_tok), .in_ep(in_ep), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_end(tx_end));

  // 25 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // APB master: request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] st, output logic [31:0] r);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge clk_sys);
    penable <= 1'b1;
    repeat (50)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1)
        break;
    end
    r        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] r;
    apb(1'b1, a, wd, 4'hf, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, 4'h0, r);
  endtask : rd

  // Expected command block word, little-endian
  function automatic logic [31:0] word_of(input int k);
    return {cbw[4*k+3], cbw[4*k+2], cbw[4*k+1], cbw[4*k]};
  endfunction : word_of

  // One IN token; length, end pulse and bytes against the memory model
  task automatic in_chk(input logic [2:0] ep, input bit ex_end, input int n, input int base);
    bit ended;
    upfm_usb_host_i.in_token(ep, ended);
    chk("packet end", {31'h0, ex_end}, {31'h0, ended});
    chk("packet length", n, upfm_usb_host_i.rx_q.size());
    for (int i = 0; i < upfm_usb_host_i.rx_q.size(); i++)
      chk("packet byte", {24'h0, mem[base+i]}, {24'h0, upfm_usb_host_i.rx_q[i]});
  endtask : in_chk

  task automatic rand_pkt(input int n, input int base);
    pkt = {};
    for (int i = 0; i < n; i++)
    begin
      pkt.push_back(8'($urandom()));
      mem[base+i] = pkt[i];
    end
  endtask : rand_pkt

  // Watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    {srst, psel, penable, pwrite, last_err} = 5'h10;
    {paddr, pwdata, pstrb} = '0;
    fail_count = 0;
    n_checks = 0;
    void'($urandom(32'hb5b1));
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    rd(`UPFM_MAXP, rdv);
    chk("max packet reset", 32'h40, rdv);
    chk("mapped error", 32'h0, {31'h0, last_err});
    chk("ready", 32'h1, {31'h0, pready});
    rd(`UPFM_STS, rdv);
    chk("status reset", 32'h0, rdv);
    rd(12'h0fc, rdv);
    chk("unmapped error", 32'h1, {31'h0, last_err});
    chk("unmapped data", 32'h0, rdv);
    // Write window with random lanes at 0x40
    wptr = 32'h40;
    wr(`UPFM_WPTR, wptr);
    for (int w = 0; w < 7; w++)
    begin
      // First write uses every lane so the full pointer step is seen
      s = (w == 0) ? 4'hf : 4'($urandom_range(15, 1));
      d = $urandom();
      apb(1'b1, `UPFM_WWIN, d, s, rdv);
      for (int j = 0; j < 4; j++)
      begin
        if (s[j])
        begin
          mem[wptr[7:0]] = d[8*j +: 8];
          wptr = wptr + 32'h1;
        end
      end
    end
    rd(`UPFM_WPTR, rdv);
    chk("write pointer", wptr, rdv);
    rd(`UPFM_WWIN, rdv);
    chk("write window read", 32'h0, rdv);
    // Descriptor reply of 6 bytes, max packet 4: full, short, then empty packet
    wr(`UPFM_MAXP, 32'h4);
    wr(`UPFM_DADR, 32'h40);
    wr(`UPFM_DSIZE, 32'h6);
    wr(`UPFM_CTRL, 32'h6);
    in_chk(3'd1, 1'b0, 0, 0);
    in_chk(3'd0, 1'b1, 4, 32'h40);
    in_chk(3'd0, 1'b1, 2, 32'h44);
    in_chk(3'd0, 1'b1, 0, 0);
    upfm_usb_host_i.pulse_out_tok();
    rd(`UPFM_STS, rdv);
    chk("descriptor done", 32'h1, rdv);
    rd(`UPFM_CTRL, rdv);
    chk("reply disarmed", 32'h4, rdv);
    wr(`UPFM_STS, 32'h1);
    // Area 0 on endpoint a: push, pop, clear
    wr(`UPFM_ACFG, 32'h0087_0080);
    wr(`UPFM_AJOIN, 32'h2);
    // Area start inside the fixed regions is pulled up to the first free byte
    wr(12'(`UPFM_ACFG + 4), 32'h0035_0010);
    rd(12'(`UPFM_ACFG + 4), rdv);
    chk("area start clamp", 32'h0035_0030, rdv);
    rand_pkt(5, 32'h80);
    upfm_usb_host_i.send_out(3'd1, pkt);
    rd(`UPFM_AOCC, rdv);
    chk("occupancy", 32'h5, rdv & 32'h3ffff);
    in_chk(3'd1, 1'b1, 4, 32'h80);
    rd(`UPFM_AOCC, rdv);
    chk("occupancy after pop", 32'h1, rdv & 32'h3ffff);
    wr(`UPFM_ACLR, 32'h1);
    rd(`UPFM_AOCC, rdv);
    chk("occupancy cleared", 32'h10000, rdv & 32'h3ffff);
    // Cleared area bytes still served by a reply from unused space
    wr(`UPFM_DADR, 32'h80);
    wr(`UPFM_DSIZE, 32'h3);
    // Armed but OUT direction: endpoint 0 stays silent
    wr(`UPFM_CTRL, 32'h2);
    in_chk(3'd0, 1'b0, 0, 0);
    wr(`UPFM_CTRL, 32'h6);
    in_chk(3'd0, 1'b1, 3, 32'h80);
    upfm_usb_host_i.pulse_out_tok();
    wr(`UPFM_STS, 32'h1);
    // Command block of 31 bytes on endpoint a
    wr(`UPFM_CTRL, 32'h104);
    rand_pkt(31, 0);
    for (int i = 0; i < 31; i++)
      cbw[i] = pkt[i];
    cbw[31] = 8'h00;
    upfm_usb_host_i.send_out(3'd1, pkt);
    rd(`UPFM_STS, rdv);
    chk("no length error", 32'h0, rdv & 32'h4);
    rd(`UPFM_AOCC, rdv);
    chk("area untouched", 32'h10000, rdv & 32'h3ffff);
    wr(`UPFM_RDCTL, 32'h1);
    repeat (40)
    begin
      rd(`UPFM_STS, rdv);
      if (rdv[1] === 1'b1)
        break;
    end
    chk("read complete", 32'h2, rdv & 32'h2);
    for (int k = 0; k < 8; k++)
    begin
      rd(12'(`UPFM_RWIN + 4*k), rdv);
      chk("read window", word_of(k) & (k == 7 ? 32'h00ffffff : '1),
          rdv & (k == 7 ? 32'h00ffffff : '1));
    end
    rand_pkt(30, 0);
    upfm_usb_host_i.send_out(3'd1, pkt);
    rd(`UPFM_STS, rdv);
    chk("length error", 32'h4, rdv & 32'h4);
    rd(`UPFM_AOCC, rdv);
    chk("bad block dropped", 32'h10000, rdv & 32'h3ffff);
    // Fill area 0 past its size, then look at port 1
    wr(`UPFM_CTRL, 32'h4);
    rand_pkt(20, 32'h80);
    upfm_usb_host_i.send_out(3'd1, pkt);
    rd(`UPFM_AOCC, rdv);
    chk("full flag", 32'h1, {31'h0, rdv[17]});
    upfm_usb_host_i.set_port(1'b1);
    upfm_usb_host_i.send_out(3'd1, pkt);
    wr(`UPFM_CTRL, 32'h5);
    rd(`UPFM_AOCC, rdv);
    chk("port 1 area", 32'h10000, rdv & 32'h3ffff);
    wrap_up();
  end
endmodule : usb_port_fifo_area_manager_bench
